// ---- common/ir_ext_params.svh ----
`ifndef IR_EXT_PARAMS_SVH
`define IR_EXT_PARAMS_SVH
// Register offsets: the bank 2/3 registers are flattened into one 4-bit space
`define IR_OFF_REVID 4'h0
`define IR_OFF_LCSHADOW 4'h1
`define IR_OFF_QCSHADOW 4'h2
`define IR_OFF_EXT2 4'h4
`define IR_OFF_RSVD05 4'h5
`define IR_OFF_TXLVL 4'h6
`define IR_OFF_RXLVL 4'h7
`define IR_OFF_EXT1 4'h8
`define IR_OFF_LINECTL 4'h9
`define IR_OFF_QCTL 4'hA
`define IR_OFF_DIVLO 4'hB
`define IR_OFF_DIVHI 4'hC
// Field positions
`define IR_EXT1_EXTSEL 0
`define IR_EXT1_LOOP 4
`define IR_EXT1_TXLB 5
`define IR_EXT1_BAUDTEST 7
`define IR_EXT2_LOCK 7
`define IR_EXT2_TXSIZE 0
`define IR_EXT2_RXSIZE 2
`define IR_EXT2_PRE 4
`define IR_QCTL_ENABLE 0
// Reset values and masks
`define IR_EXT1_RESET 8'h00
`define IR_EXT2_RESET 8'h00
`define IR_EXT1_WMASK 8'hBF
`define IR_EXT2_WMASK 8'hBF
`define IR_LEVEL_MASK 8'h3F
// Prescaler: 24 MHz reference divided by 13, 1.625 (13/8) or 1
`define IR_PRE_NUM13 8'h0D
`define IR_PRE_STEP_FRAC 8'h08
// Queue depths reported to the engine
`define IR_DEPTH_SMALL 6'h10
`define IR_DEPTH_LARGE 6'h20
`endif

// ---- common/ir_ext_pkg.sv ----
`default_nettype none
package ir_ext_pkg;
	typedef enum logic [1:0] {DEPTH16 = 2'b00, DEPTH32 = 2'b01} depth_e;
	typedef enum logic [1:0] {PRE13 = 2'b00, PRE1625 = 2'b01, PRERSVD = 2'b10, PRE1 = 2'b11} pre_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed {
		logic [7:0] ext1;
		logic [7:0] ext2;
		logic [7:0] lineCtl;
		logic [7:0] queueCtl;
		logic [15:0] divisor;
		logic [15:0] scratch;
		logic [7:0] rdata;
		logic [7:0] preAcc;
		logic baudTick;
		logic [15:0] divCnt;
		logic baudOut;
		logic [1:0] txPinSync;
		logic [1:0] irPinSync;
	} state_s;
endpackage
`default_nettype wire

// ---- src/serial_ir_ext_control_regs.sv ----
// Behaviour
// RULE1: tx-in-loopback bit keeps transmitter driving
// RULE2: baud test bit routes baud onto DTR
// RULE3: queue depth codes 16/32, only when enabled
// RULE4: prescaler divides reference by 13/1.625/1
// RULE5: lock blocks legacy divisor and fallback
// RULE6: locked legacy divisor accesses hit scratchpads
// RULE7: software keeps lock clear in extended mode
// RULE8: extended control two resets to zero
// RULE9: transmit level register, six-bit count
// RULE10: receive level register, six-bit count
// RULE11: level registers show live unfrozen counts
// RULE12: software reads level three times
// RULE13: identification: type nibble, revision nibble
// RULE14: line control shadow follows any-bank writes
// RULE15: queue control shadow reads write-only register
// RULE16: offset three decodes same in all banks
// RULE17: loopback idles serial high, infrared low
// RULE18: extended select bit enables extended mode
// RULE19: reserved bits and register read zero
`include "ir_ext_params.svh"
`default_nettype none
module serial_ir_ext_control_regs #(
	parameter logic [3:0] MODULE_TYPE = 4'h5, // Arbitrary value
	parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Legacy non-extended divisor access (same clock)
	input wire logic legacyDivWr,
	input wire logic legacyDivHigh,
	input wire logic [7:0] legacyDivData,
	output logic [7:0] legacyDivRdata,
	// Live queue counts from the serial engine (same clock)
	input wire logic [5:0] transmitQueueCount,
	input wire logic [5:0] receiveQueueCount,
	// Engine serial outputs (TX and IR pins from another domain)
	input wire logic engineTxSerial,
	input wire logic engineIrTx,
	input wire logic engineDtrN,
	// Outputs to pins and engine
	output logic txSerialOut,
	output logic irTxOut,
	output logic dtrPinN,
	output logic extendedMode,
	output logic fallbackAllowed,
	output logic loopbackActive,
	output logic [5:0] transmitQueueDepth,
	output logic [5:0] receiveQueueDepth,
	output logic [15:0] baudDivisor,
	output logic baudClockTick
);
	ir_ext_pkg::state_s s_q, s_d;
	ir_ext_pkg::bus_req_s req;
	logic locked;
	logic [7:0] readMux;
	logic [8:0] preSum;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign locked = s_q.ext2[`IR_EXT2_LOCK];

	always_comb begin
		unique case (req.addr)
			`IR_OFF_REVID: readMux = {MODULE_TYPE, REVISION}; // RULE13
			`IR_OFF_LCSHADOW: readMux = s_q.lineCtl; // RULE14
			`IR_OFF_QCSHADOW: readMux = s_q.queueCtl; // RULE15
			`IR_OFF_EXT2: readMux = s_q.ext2;
			`IR_OFF_TXLVL: readMux = {2'b00, transmitQueueCount}; // RULE9 RULE11
			`IR_OFF_RXLVL: readMux = {2'b00, receiveQueueCount}; // RULE10 RULE11
			`IR_OFF_EXT1: readMux = s_q.ext1;
			`IR_OFF_LINECTL: readMux = s_q.lineCtl; // RULE16
			default: readMux = 8'h00; // RULE19
		endcase
	end

	// Prescaler as fractional accumulator: step 8 out of 13 yields 24/1.625
	always_comb begin
		unique case (ir_ext_pkg::pre_e'(s_q.ext2[`IR_EXT2_PRE +: 2])) // RULE4
			ir_ext_pkg::PRE13: preSum = {1'b0, s_q.preAcc} + 9'h001;
			ir_ext_pkg::PRE1625: preSum = {1'b0, s_q.preAcc} + {1'b0, `IR_PRE_STEP_FRAC};
			ir_ext_pkg::PRE1: preSum = {1'b0, `IR_PRE_NUM13};
			default: preSum = 9'h000; // Reserved code stops the baud clock
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.txPinSync = {s_q.txPinSync[0], engineTxSerial};
		s_d.irPinSync = {s_q.irPinSync[0], engineIrTx};
		if (req.rd) begin
			s_d.rdata = readMux;
		end
		if (req.wr) begin
			unique case (req.addr)
				`IR_OFF_EXT1: s_d.ext1 = req.wdata & `IR_EXT1_WMASK;
				`IR_OFF_EXT2: s_d.ext2 = req.wdata & `IR_EXT2_WMASK; // RULE19
				`IR_OFF_LINECTL: s_d.lineCtl = req.wdata; // RULE14 RULE16
				`IR_OFF_QCTL: s_d.queueCtl = req.wdata;
				`IR_OFF_DIVLO: s_d.divisor[7:0] = req.wdata;
				`IR_OFF_DIVHI: s_d.divisor[15:8] = req.wdata;
				default: s_d.rdata = s_d.rdata;
			endcase
		end
		// Locked legacy writes land in scratchpads; divisor untouched
		if (legacyDivWr) begin
			if (locked) begin
				if (legacyDivHigh) begin // RULE6
					s_d.scratch[15:8] = legacyDivData;
				end else begin
					s_d.scratch[7:0] = legacyDivData;
				end
			end else if (legacyDivHigh) begin // RULE5
				s_d.divisor[15:8] = legacyDivData;
			end else begin
				s_d.divisor[7:0] = legacyDivData;
			end
		end
		s_d.baudTick = 1'b0;
		if (preSum >= {1'b0, `IR_PRE_NUM13}) begin
			s_d.preAcc = 8'(preSum - {1'b0, `IR_PRE_NUM13});
			if (s_q.divCnt <= 16'h0001) begin
				s_d.divCnt = s_q.divisor;
				s_d.baudTick = (s_q.divisor != 16'h0000);
				s_d.baudOut = ~s_q.baudOut;
			end else begin
				s_d.divCnt = s_q.divCnt - 16'h0001;
			end
		end else begin
			s_d.preAcc = preSum[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0; // RULE8
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	// Legacy read path: divisor or scratchpad, held combinationally
	always_comb begin
		if (locked) begin
			legacyDivRdata = legacyDivHigh ? s_q.scratch[15:8] : s_q.scratch[7:0]; // RULE6
		end else begin
			legacyDivRdata = legacyDivHigh ? s_q.divisor[15:8] : s_q.divisor[7:0];
		end
	end

	always_comb begin
		if (s_q.ext1[`IR_EXT1_LOOP] && !s_q.ext1[`IR_EXT1_TXLB]) begin // RULE17
			txSerialOut = 1'b1;
			irTxOut = 1'b0;
		end else begin // RULE1
			txSerialOut = s_q.txPinSync[1];
			irTxOut = s_q.irPinSync[1];
		end
	end

	// Engine DTR is same-domain logic; test mode shows the baud square wave
	assign dtrPinN = s_q.ext1[`IR_EXT1_BAUDTEST] ? s_q.baudOut : engineDtrN; // RULE2
	assign extendedMode = s_q.ext1[`IR_EXT1_EXTSEL]; // RULE18
	assign fallbackAllowed = !locked; // RULE5
	assign loopbackActive = s_q.ext1[`IR_EXT1_LOOP];
	assign rdata = s_q.rdata;
	assign baudDivisor = s_q.divisor;
	assign baudClockTick = s_q.baudTick;
	// Reserved depth codes fall back to 16; depth is 16 while queues are off
	assign transmitQueueDepth = (s_q.queueCtl[`IR_QCTL_ENABLE]
		&& s_q.ext2[`IR_EXT2_TXSIZE +: 2] == ir_ext_pkg::DEPTH32) ? `IR_DEPTH_LARGE : `IR_DEPTH_SMALL; // RULE3
	assign receiveQueueDepth = (s_q.queueCtl[`IR_QCTL_ENABLE]
		&& s_q.ext2[`IR_EXT2_RXSIZE +: 2] == ir_ext_pkg::DEPTH32) ? `IR_DEPTH_LARGE : `IR_DEPTH_SMALL; // RULE3
endmodule
`default_nettype wire

// ---- verification/serial_ir_ext_control_regs_chk.sv ----
`default_nettype none
module serial_ir_ext_control_regs_chk #(
	parameter logic [3:0] MODULE_TYPE = 4'h5,
	parameter logic [3:0] REVISION = 4'h1
) (
	// Observed ports
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic legacyDivWr,
	input wire logic legacyDivHigh,
	input wire logic [7:0] legacyDivData,
	input wire logic [5:0] transmitQueueCount,
	input wire logic [5:0] receiveQueueCount,
	input wire logic extendedMode,
	input wire logic fallbackAllowed,
	input wire logic [15:0] baudDivisor
);
	logic rdOk;
	assign rdOk = rd && clkEn;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rstLock; $fell(rst) |-> fallbackAllowed; endproperty
	a_rstLock: assert property (p_rstLock) else $error("lock set after reset");
	property p_lockWr; wr && clkEn && addr == 4'h4 |=> fallbackAllowed == !$past(wdata[7]); endproperty
	a_lockWr: assert property (p_lockWr) else $error("lock bit not applied");
	property p_txLvl; rdOk && addr == 4'h6 |=> rdata == {2'h0, $past(transmitQueueCount)}; endproperty
	a_txLvl: assert property (p_txLvl) else $error("transmit level wrong");
	property p_rxLvl; rdOk && addr == 4'h7 |=> rdata == {2'h0, $past(receiveQueueCount)}; endproperty
	a_rxLvl: assert property (p_rxLvl) else $error("receive level wrong");
	property p_id; rdOk && addr == 4'h0 |=> rdata == {MODULE_TYPE, REVISION}; endproperty
	a_id: assert property (p_id) else $error("identification wrong");
	property p_rsvd; rdOk && addr == 4'h5 |=> rdata == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
	property p_scratch; legacyDivWr && clkEn && !fallbackAllowed |=> $stable(baudDivisor); endproperty
	a_scratch: assert property (p_scratch) else $error("locked write changed divisor");
	property p_legacy;
		legacyDivWr && clkEn && fallbackAllowed && !extendedMode && !legacyDivHigh
			|=> baudDivisor[7:0] == $past(legacyDivData);
	endproperty
	a_legacy: assert property (p_legacy) else $error("unlocked write lost");
	property p_shadow; wr && clkEn && addr == 4'h9 ##1 rdOk && addr == 4'h1 |=> rdata == $past(wdata, 2); endproperty
	a_shadow: assert property (p_shadow) else $error("line shadow stale");
	cover property (rdOk && addr == 4'h6);
	cover property (legacyDivWr && !fallbackAllowed);
	cover property (wr && addr == 4'h9 ##1 rd && addr == 4'h1);
endmodule
bind serial_ir_ext_control_regs serial_ir_ext_control_regs_chk #(.MODULE_TYPE(MODULE_TYPE), .REVISION(REVISION))
	chk_i (.clk, .rst, .clkEn, .addr, .wdata, .wr, .rd, .rdata, .legacyDivWr, .legacyDivHigh, .legacyDivData,
	.transmitQueueCount, .receiveQueueCount, .extendedMode, .fallbackAllowed, .baudDivisor);
`default_nettype wire

// ---- verification/serial_ir_ext_control_regs_test.sv ----
`default_nettype none
module serial_ir_ext_control_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, clkEn = 1, wr = 0, rd = 0, rdLate = 0;
	logic legacyDivWr = 0, legacyDivHigh = 0, engineDtrN = 0, fallbackAllowed;
	logic engineTxSerial = 0, engineIrTx = 0, txSerialOut, irTxOut, dtrPinN, extendedMode, loopbackActive;
	logic baudClockTick, last;
	logic [5:0] transmitQueueDepth, receiveQueueDepth;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, legacyDivData = 8'h00, rdata, legacyDivRdata, v;
	logic [5:0] transmitQueueCount = 6'h00, receiveQueueCount = 6'h00;
	logic [15:0] baudDivisor;
	// Ticks in 26 cycles for prescaler codes 0 to 3: divide by 13, 1.625, stopped, 1
	logic [15:0] expTick [4] = '{16'h2, 16'h10, 16'h0, 16'h1A};
	logic [7:0] expQ[$];
	int errors = 0, n_tests = 0, ticks, toggles;
	// Identification values are arbitrary
	serial_ir_ext_control_regs #(.MODULE_TYPE(4'h3), .REVISION(4'h2)) serial_ir_ext_control_regs_i (.clk, .rst,
		.clkEn, .addr, .wdata, .wr, .rd, .rdata, .legacyDivWr, .legacyDivHigh, .legacyDivData, .legacyDivRdata,
		.transmitQueueCount, .receiveQueueCount, .engineTxSerial, .engineIrTx, .engineDtrN,
		.txSerialOut, .irTxOut, .dtrPinN, .extendedMode, .fallbackAllowed, .loopbackActive,
		.transmitQueueDepth, .receiveQueueDepth, .baudDivisor, .baudClockTick);
	initial forever #4 clk = ~clk;
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		legacyDivWr <= 0;
	endtask
	task rdReg(input logic [3:0] a, input logic [7:0] e);
		bus(0, 1, a, 8'h00);
		expQ.push_back(e);
	endtask
	task legacy(input logic h, input logic [7:0] d);
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		legacyDivWr <= 1;
		legacyDivHigh <= h;
		legacyDivData <= d;
	endtask
	task settle;
		bus(0, 0, 4'h0, 8'h00);
		@(negedge clk);
	endtask
	always @(posedge clk) rdLate <= rd;
	// Read data is looked at mid-cycle, once the register has settled
	always @(negedge clk) if (rdLate) check(rdata, expQ.pop_front());
	initial begin
		v = 8'($urandom(32'hCE58E4BB));
		repeat (20) @(posedge clk);
		rst <= 0;
		check(fallbackAllowed, 16'h1);
		rdReg(4'h4, 8'h00);
		rdReg(4'h0, 8'h32);
		bus(1, 0, 4'h5, 8'hFF);
		rdReg(4'h5, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			transmitQueueCount <= v[5:0];
			receiveQueueCount <= ~v[5:0];
			engineDtrN <= v[7];
			rdReg(4'h6, {2'h0, v[5:0]});
			rdReg(4'h7, {2'h0, ~v[5:0]});
			bus(1, 0, 4'h9, v);
			rdReg(4'h1, v);
		end
		bus(1, 0, 4'hA, 8'h81);
		rdReg(4'h2, 8'h81);
		bus(1, 0, 4'h4, 8'h7F);
		rdReg(4'h4, 8'h3F);
		legacy(0, 8'hA5);
		legacy(1, 8'h5A);
		settle;
		check(baudDivisor, 16'h5AA5);
		check(dtrPinN, engineDtrN);
		bus(1, 0, 4'h4, 8'h80);
		settle;
		check(fallbackAllowed, 16'h0);
		legacy(0, 8'h11);
		settle;
		check(baudDivisor, 16'h5AA5);
		check(legacyDivRdata, 16'h11);
		// Mid-run reset must drop the lock that is still set
		@(posedge clk);
		rst <= 1;
		engineIrTx <= 1;
		@(posedge clk);
		rst <= 0;
		rdReg(4'h4, 8'h00);
		repeat (3) rdReg(4'h6, {2'h0, v[5:0]});
		bus(1, 0, 4'hB, 8'h01);
		bus(1, 0, 4'hC, 8'h00);
		bus(1, 0, 4'h8, 8'h10);
		settle;
		check(txSerialOut, 16'h1);
		check(irTxOut, 16'h0);
		check(loopbackActive, 16'h1);
		bus(1, 0, 4'h8, 8'h31);
		settle;
		check(txSerialOut, 16'h0);
		check(irTxOut, 16'h1);
		check(extendedMode, 16'h1);
		bus(1, 0, 4'h8, 8'h80);
		for (int c = 0; c < 4; c++) begin
			bus(1, 0, 4'hA, 8'(c != 0));
			bus(1, 0, 4'h4, {2'b00, 2'(c), 4'h5});
			settle;
			check(transmitQueueDepth, c == 0 ? 16'h10 : 16'h20);
			check(receiveQueueDepth, c == 0 ? 16'h10 : 16'h20);
			ticks = 0;
			toggles = 0;
			last = dtrPinN;
			repeat (26) begin
				@(negedge clk);
				ticks += int'(baudClockTick);
				toggles += int'(dtrPinN !== last);
				last = dtrPinN;
			end
			check(16'(ticks), expTick[c]);
			check(16'(toggles), expTick[c]);
		end
		print_verdict;
	end
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		print_verdict;
	end
endmodule
`default_nettype wire
